// >>> aacbe_pkg.sv
`default_nettype none
package aacbe_pkg;
    localparam int unsigned PC_W = 21;
    localparam int unsigned FA_W = 12;
    localparam int unsigned ADDR_W = 8;

    // Register byte offsets on the APB port.
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WREG   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BANK   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PC     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IDXB   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h18;

    // Field positions.
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_EXT = 1;
    localparam int unsigned FLG_C    = 0;
    localparam int unsigned FLG_DC   = 1;
    localparam int unsigned FLG_Z    = 2;
    localparam int unsigned FLG_OV   = 3;
    localparam int unsigned FLG_N    = 4;
    localparam int unsigned BIT_D    = 9;
    localparam int unsigned BIT_A    = 8;

    // Opcode patterns.
    localparam logic [5:0] OPC_ADD_WREG_FILE_WITH_CARRY = 6'h08;
    localparam logic [5:0] OPC_AND_WREG_FILE            = 6'h05;
    localparam logic [7:0] OPC_AND_LITERAL_INTO_WREG    = 8'h0B;
    localparam logic [7:0] OPC_BRANCH_ON_CARRY_SET      = 8'hE2;

    // Addressing constants.
    localparam logic [7:0]      IDX_MAX_F   = 8'h5F;
    localparam logic [7:0]      ACC_SPLIT   = 8'h60;
    localparam logic [3:0]      ACC_HI_BANK = 4'hF;
    localparam logic [3:0]      ACC_LO_BANK = 4'h0;
    localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;

    // Reset values.
    localparam logic [1:0]      CTRL_RST   = 2'h0;
    localparam logic [4:0]      STATUS_RST = 5'h00;
    localparam logic [7:0]      WREG_RST   = 8'h00;
    localparam logic [3:0]      BANK_RST   = 4'h0;
    localparam logic [PC_W-1:0] PC_RST     = 21'h000000;
    localparam logic [FA_W-1:0] IDXB_RST   = 12'h000;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} aacbe_qph_t;
    typedef enum logic [2:0] {OP_NOP, OP_ADDC, OP_ANDF, OP_ANDL, OP_BC} aacbe_op_t;
endpackage
`default_nettype wire

// >>> aacbe_exec.sv
// Functional notes
// - Opcode 0010 00da adds working register, carry and file register to destination.
// - Add with carry updates negative, overflow, carry, digit carry and zero.
// - Destination bit 0 writes working register; 1 writes the file register.
// - Access bit 0 picks access bank; 1 uses bank pointer for upper bits.
// - Extended set, access bit 0, operand up to 95 selects indexed literal offset.
// - File instructions decode Q1, read Q2, process Q3, write Q4.
// - AND literal combines working register with low byte into working register.
// - Both AND forms update only negative and zero flags.
// - Opcode 0001 01da ANDs working register with file register to destination.
// - Opcode 1110 0010 branches only when carry is 1, else falls through.
// - Taken branch adds twice the signed 8-bit offset to incremented counter.
// - Untaken branch takes one cycle; taken adds one cycle of no-operations.
// - Branch on carry leaves every status flag unchanged.
// - Target uses counter already incremented past the branch word.
//
// Implementation choices: the placing of the registers and register access over APB.
`default_nettype none
module aacbe_exec
    import aacbe_pkg::*;
(
    input  wire logic                         pclk,         // Core clock.
    input  wire logic                         presetn,      // Asynchronous reset, active low.
    input  wire logic                         clk_en,       // Freezes all state while low.
    input  wire logic                         psel,         // APB select.
    input  wire logic                         penable,      // APB enable.
    input  wire logic                         pwrite,       // APB direction.
    input  wire logic [aacbe_pkg::ADDR_W-1:0] paddr,        // APB byte address.
    input  wire logic [31:0]                  pwdata,       // APB write data.
    output logic      [31:0]                  prdata,       // APB read data.
    output logic                              pready,       // APB ready.
    output logic                              pslverr,      // APB error on unmapped address.
    output logic      [aacbe_pkg::PC_W-1:0]   prog_addr,    // Program memory byte address.
    input  wire logic [15:0]                  prog_data,    // Instruction word at prog_addr.
    output logic      [aacbe_pkg::FA_W-1:0]   file_addr,    // Data memory address.
    output logic                              file_rd_en,   // Data memory read strobe.
    input  wire logic [7:0]                   file_rd_data, // Data memory read data.
    output logic                              file_wr_en,   // Data memory write strobe.
    output logic      [7:0]                   file_wr_data, // Data memory write data.
    output aacbe_pkg::aacbe_qph_t             q_phase       // Current instruction phase.
);
    import aacbe_pkg::*;

    logic [1:0]      ctrl_reg;
    logic [4:0]      status_reg;
    logic [7:0]      wreg_reg;
    logic [3:0]      bank_reg;
    logic [PC_W-1:0] pc_reg;
    logic [FA_W-1:0] idxb_reg;
    aacbe_qph_t      qph_reg;
    aacbe_op_t       op_reg;
    logic [15:0]     instr_reg;
    logic [7:0]      opnd_reg;
    logic [7:0]      result_reg;
    logic [4:0]      flags_reg;
    logic            flush_reg;
    logic [FA_W-1:0] file_addr_reg;
    logic            file_rd_reg;
    logic            file_wr_reg;
    logic [7:0]      file_wd_reg;
    logic [31:0]     prdata_reg;

    logic            adv;
    logic            apb_wr;
    logic            mapped;
    logic            dest_file;
    logic            is_file_op;
    logic            take_branch;
    logic [8:0]      add_sum;
    logic [4:0]      add_nib;
    logic [7:0]      and_val;
    logic [7:0]      alu_res;
    logic [4:0]      alu_flags;
    logic [PC_W-1:0] br_target;

    function automatic aacbe_op_t decode_op(input logic [15:0] i);
        if (i[15:10] == OPC_ADD_WREG_FILE_WITH_CARRY) begin
            return OP_ADDC;
        end else if (i[15:10] == OPC_AND_WREG_FILE) begin
            return OP_ANDF;
        end else if (i[15:8] == OPC_AND_LITERAL_INTO_WREG) begin
            return OP_ANDL;
        end else if (i[15:8] == OPC_BRANCH_ON_CARRY_SET) begin
            return OP_BC;
        end
        return OP_NOP;
    endfunction

    function automatic logic [FA_W-1:0] file_address(
        input logic [7:0]      f,
        input logic            acc,
        input logic            ext,
        input logic [3:0]      bank,
        input logic [FA_W-1:0] base
    );
        if (acc) begin
            return {bank, f};
        end else if (ext && f <= IDX_MAX_F) begin
            return FA_W'(base + {4'h0, f});
        end else if (f < ACC_SPLIT) begin
            return {ACC_LO_BANK, f};
        end
        return {ACC_HI_BANK, f};
    endfunction

    assign adv        = clk_en && ctrl_reg[CTRL_RUN];
    assign dest_file  = instr_reg[BIT_D];
    assign is_file_op = (op_reg == OP_ADDC) || (op_reg == OP_ANDF);

    // Arithmetic for the process phase.
    assign add_sum = {1'b0, wreg_reg} + {1'b0, opnd_reg} + {8'h00, status_reg[FLG_C]};
    assign add_nib = {1'b0, wreg_reg[3:0]} + {1'b0, opnd_reg[3:0]} + {4'h0, status_reg[FLG_C]};
    assign and_val = (op_reg == OP_ANDL) ? instr_reg[7:0] : opnd_reg;

    always_comb begin
        alu_res   = wreg_reg & and_val;
        alu_flags = status_reg;
        if (op_reg == OP_ADDC) begin
            alu_res           = add_sum[7:0];
            alu_flags[FLG_C]  = add_sum[8];
            alu_flags[FLG_DC] = add_nib[4];
            alu_flags[FLG_OV] = (wreg_reg[7] == opnd_reg[7]) && (add_sum[7] != wreg_reg[7]);
        end
        alu_flags[FLG_N] = alu_res[7];
        alu_flags[FLG_Z] = (alu_res == 8'h00);
    end

    assign take_branch = (op_reg == OP_BC) && status_reg[FLG_C];
    assign br_target   = PC_W'(pc_reg + {{(PC_W-9){instr_reg[7]}}, instr_reg[7:0], 1'b0});

    // Phase sequencer; holds its current phase while the core is stopped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qph_reg <= Q1;
        end else if (adv) begin
            unique case (qph_reg)
                Q1: qph_reg <= Q2;
                Q2: qph_reg <= Q3;
                Q3: qph_reg <= Q4;
                Q4: qph_reg <= Q1;
            endcase
        end
    end

    // Decode at the end of Q1; a refill cycle decodes nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg    <= OP_NOP;
            instr_reg <= 16'h0000;
        end else if (adv && qph_reg == Q1) begin
            op_reg    <= flush_reg ? OP_NOP : decode_op(prog_data);
            instr_reg <= flush_reg ? 16'h0000 : prog_data;
        end
    end

    // Data memory read in Q2 and write in Q4.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            file_addr_reg <= {FA_W{1'b0}};
            file_rd_reg   <= 1'b0;
            file_wr_reg   <= 1'b0;
            file_wd_reg   <= 8'h00;
            opnd_reg      <= 8'h00;
        end else if (adv) begin
            file_rd_reg <= 1'b0;
            file_wr_reg <= 1'b0;
            if (qph_reg == Q1 && !flush_reg) begin
                file_addr_reg <= file_address(prog_data[7:0], prog_data[BIT_A], ctrl_reg[CTRL_EXT],
                                              bank_reg, idxb_reg);
                file_rd_reg   <= (decode_op(prog_data) == OP_ADDC) || (decode_op(prog_data) == OP_ANDF);
            end
            if (qph_reg == Q2) begin
                opnd_reg <= file_rd_data;
            end
            if (qph_reg == Q3) begin
                file_wr_reg <= is_file_op && dest_file;
                file_wd_reg <= alu_res;
            end
        end
    end

    // Process in Q3.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 8'h00;
            flags_reg  <= STATUS_RST;
        end else if (adv && qph_reg == Q3) begin
            result_reg <= alu_res;
            flags_reg  <= alu_flags;
        end
    end

    // Second cycle of a taken branch is a whole cycle of no-operations.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_reg <= 1'b0;
        end else if (adv && qph_reg == Q4) begin
            flush_reg <= !flush_reg && take_branch;
        end
    end

    // APB slave: zero wait states, registered read data.
    assign apb_wr  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_WREG) || (paddr == OFS_BANK)
                     || (paddr == OFS_PC) || (paddr == OFS_IDXB) || (paddr == OFS_STATE);
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (clk_en && psel && !penable) begin
            unique case (paddr)
                OFS_CTRL:   prdata_reg <= {30'h0, ctrl_reg};
                OFS_STATUS: prdata_reg <= {27'h0, status_reg};
                OFS_WREG:   prdata_reg <= {24'h0, wreg_reg};
                OFS_BANK:   prdata_reg <= {28'h0, bank_reg};
                OFS_PC:     prdata_reg <= {11'h0, pc_reg};
                OFS_IDXB:   prdata_reg <= {20'h0, idxb_reg};
                OFS_STATE:  prdata_reg <= {10'h0, instr_reg, op_reg, flush_reg, qph_reg};
                default:    prdata_reg <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            bank_reg <= BANK_RST;
            idxb_reg <= IDXB_RST;
        end else if (clk_en && apb_wr) begin
            if (paddr == OFS_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (paddr == OFS_BANK) begin
                bank_reg <= pwdata[3:0];
            end
            if (paddr == OFS_IDXB) begin
                idxb_reg <= pwdata[FA_W-1:0];
            end
        end
    end

    // Core writes in Q4 win over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wreg_reg <= WREG_RST;
        end else if (adv && qph_reg == Q4 && (op_reg == OP_ANDL || (is_file_op && !dest_file))) begin
            wreg_reg <= result_reg;
        end else if (clk_en && apb_wr && paddr == OFS_WREG) begin
            wreg_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RST;
        end else if (adv && qph_reg == Q4 && (is_file_op || op_reg == OP_ANDL)) begin
            status_reg <= flags_reg;
        end else if (clk_en && apb_wr && paddr == OFS_STATUS) begin
            status_reg <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= PC_RST;
        end else if (adv && qph_reg == Q1 && !flush_reg) begin
            pc_reg <= PC_W'(pc_reg + PC_STEP);
        end else if (adv && qph_reg == Q4 && take_branch) begin
            pc_reg <= br_target;
        end else if (clk_en && apb_wr && paddr == OFS_PC) begin
            pc_reg <= pwdata[PC_W-1:0];
        end
    end

    assign prdata       = prdata_reg;
    assign prog_addr    = pc_reg;
    assign file_addr    = file_addr_reg;
    assign file_rd_en   = file_rd_reg;
    assign file_wr_en   = file_wr_reg;
    assign file_wr_data = file_wd_reg;
    assign q_phase      = qph_reg;

    // Checks; a stall of the core abandons any pending check.
    logic [7:0] exp_add;
    logic [7:0] exp_and;
    assign exp_add = add_sum[7:0];
    assign exp_and = wreg_reg & instr_reg[7:0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !adv);

    property p_add_to_wreg;
        qph_reg == Q3 && op_reg == OP_ADDC && !dest_file |-> ##2 wreg_reg == $past(exp_add, 2);
    endproperty
    a_add_to_wreg: assert property (p_add_to_wreg) else $error("add result missing from wreg");

    property p_add_carry;
        qph_reg == Q3 && op_reg == OP_ADDC |-> ##2 status_reg[FLG_C] == $past(add_sum[8], 2);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry flag wrong");

    property p_file_dest;
        qph_reg == Q3 && is_file_op && dest_file |=> file_wr_en && file_wr_data == $past(alu_res)
            ##1 wreg_reg == $past(wreg_reg, 2);
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file destination handled wrong");

    property p_bank_addr;
        file_rd_en && instr_reg[BIT_A] |-> file_addr == {bank_reg, instr_reg[7:0]};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");

    property p_index_addr;
        file_rd_en && !instr_reg[BIT_A] && ctrl_reg[CTRL_EXT] && instr_reg[7:0] <= IDX_MAX_F
            |-> file_addr == FA_W'(idxb_reg + {4'h0, instr_reg[7:0]});
    endproperty
    a_index_addr: assert property (p_index_addr) else $error("indexed address wrong");

    property p_phases;
        (file_rd_en |-> qph_reg == Q2) and (file_wr_en |-> qph_reg == Q4);
    endproperty
    a_phases: assert property (p_phases) else $error("memory strobe in wrong phase");

    property p_and_lit;
        qph_reg == Q3 && op_reg == OP_ANDL |-> ##2 wreg_reg == $past(exp_and, 2);
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("literal and result wrong");

    property p_and_flags;
        qph_reg == Q4 && (op_reg == OP_ANDL || op_reg == OP_ANDF)
            |=> status_reg[FLG_C] == $past(status_reg[FLG_C]) && status_reg[FLG_OV] == $past(status_reg[FLG_OV])
                && status_reg[FLG_DC] == $past(status_reg[FLG_DC]);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and touched carry, digit carry or overflow");

    property p_branch_taken;
        qph_reg == Q4 && take_branch |=> pc_reg == $past(br_target) && flush_reg;
    endproperty
    a_branch_taken: assert property (p_branch_taken) else $error("branch target wrong");

    property p_refill;
        flush_reg && qph_reg == Q1 |=> (op_reg == OP_NOP && !file_rd_en) [*4];
    endproperty
    a_refill: assert property (p_refill) else $error("refill cycle not idle");

    property p_branch_flags;
        qph_reg == Q4 && op_reg == OP_BC |=> $stable(status_reg);
    endproperty
    a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags");
endmodule // aacbe_exec
`default_nettype wire

// >>> aacbe_mem.sv
`default_nettype none
module aacbe_mem
    import aacbe_pkg::*;
(
    input  wire logic                       pclk,         // Core clock.
    input  wire logic [aacbe_pkg::PC_W-1:0] prog_addr,    // Program byte address.
    output logic      [15:0]                prog_data,    // Instruction word.
    input  wire logic [aacbe_pkg::FA_W-1:0] file_addr,    // Data memory address.
    input  wire logic                       file_rd_en,   // Read strobe.
    output logic      [7:0]                 file_rd_data, // Read data.
    input  wire logic                       file_wr_en,   // Write strobe.
    input  wire logic [7:0]                 file_wr_data  // Write data.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prog [0:255];
    logic [7:0]  dmem [0:4095];
    logic [7:0]  last_q = 8'h00;
    assign prog_data = prog[prog_addr[8:1]];
    // Outside a read strobe the bus shows the inverse of the last value, so stale data is never trusted.
    assign file_rd_data = file_rd_en ? dmem[file_addr] : ~last_q;
    always @(posedge pclk) begin
        if (file_rd_en) begin
            last_q <= dmem[file_addr];
        end
        if (file_wr_en) begin
            dmem[file_addr] <= file_wr_data;
        end
    end
endmodule // aacbe_mem
`default_nettype wire

// >>> add_and_carry_branch_exec_test.sv
`default_nettype none
module add_and_carry_branch_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aacbe_pkg::*;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, file_rd_en, file_wr_en, er;
    logic [7:0]  paddr, file_rd_data, file_wr_data;
    logic [31:0] pwdata, prdata, rdv, rw, rs, rm, wm, ra, pc12;
    logic [15:0] prog_data;
    logic [PC_W-1:0] prog_addr;
    logic [FA_W-1:0] file_addr;
    aacbe_qph_t q_phase;
    int miscompares = 0;
    int n_checks = 0;

    aacbe_exec u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
        .file_rd_en(file_rd_en), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data), .q_phase(q_phase));
    aacbe_mem u_mem (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
        .file_rd_en(file_rd_en), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task results;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            n_checks++;
            if (g !== e) begin
                $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
                miscompares++;
            end
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
             output logic err);
        int i;
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            for (i = 0; i < 20; i++) begin
                @(posedge pclk);
                if (pready === 1'b1) break;
            end
            if (i == 20) begin
                miscompares++;
                results;
            end else begin
                rd = prdata;
                err = pslverr;
                psel    <= 1'b0;
                penable <= 1'b0;
            end
        end
    endtask

    task rst;
        int i;
        begin
            presetn <= 1'b0;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            for (i = 0; i < 256; i++) u_mem.prog[i] = 16'h0000;
        end
    endtask

    // Loads the core registers, starts it and logs strobes per cycle counted from the run edge.
    task go(input logic [7:0] w, input logic [4:0] st, input logic [3:0] bk, input logic [1:0] ct,
            input logic [20:0] pc);
        int k;
        begin
            apb(1'b1, OFS_WREG, {24'h0, w}, rdv, er);
            apb(1'b1, OFS_STATUS, {27'h0, st}, rdv, er);
            apb(1'b1, OFS_BANK, {28'h0, bk}, rdv, er);
            apb(1'b1, OFS_IDXB, 32'h200, rdv, er);
            apb(1'b1, OFS_PC, {11'h0, pc}, rdv, er);
            apb(1'b1, OFS_CTRL, {30'h0, ct}, rdv, er);
            rm = 32'h0;
            wm = 32'h0;
            ra = 32'h0;
            for (k = 0; k < 13; k++) begin
                #1;
                if (k == 0) chk({30'h0, q_phase}, {30'h0, Q1});
                if (file_rd_en === 1'b1) begin
                    if (rm == 32'h0) ra = {20'h0, file_addr};
                    rm[k] = 1'b1;
                end
                if (file_wr_en === 1'b1) wm[k] = 1'b1;
                if (k == 12) pc12 = {11'h0, prog_addr};
                @(posedge pclk);
            end
            apb(1'b0, OFS_WREG, 32'h0, rw, er);
            apb(1'b0, OFS_STATUS, 32'h0, rs, er);
        end
    endtask

    task s_regs;
        int i;
        logic [7:0] ofs [7];
        begin
            ofs = '{OFS_CTRL, OFS_STATUS, OFS_WREG, OFS_BANK, OFS_PC, OFS_IDXB, OFS_STATE};
            rst;
            for (i = 0; i < 7; i++) begin
                apb(1'b0, ofs[i], 32'h0, rdv, er);
                chk(rdv, 32'h0);
            end
            apb(1'b1, OFS_PC, 32'hFFFFFFFF, rdv, er);
            apb(1'b0, OFS_PC, 32'h0, rdv, er);
            chk(rdv, 32'h1FFFFF);
            apb(1'b0, 8'h1C, 32'h0, rdv, er);
            chk({31'h0, er}, 32'h1);
        end
    endtask

    task s_addc_w;
        begin
            rst;
            u_mem.dmem[12'h010] = 8'hC2;
            u_mem.prog[0] = 16'h2010;
            go(8'h17, 5'h01, 4'h0, 2'h1, 21'h0);
            chk(rw, 32'hDA);
            chk(rs, 32'h10);
            chk(ra, 32'h010);
            chk(rm, 32'h2);
            chk(wm, 32'h0);
            chk({24'h0, u_mem.dmem[12'h010]}, 32'hC2);
            chk(pc12, 32'h6);
        end
    endtask

    task s_addc_bank;
        begin
            rst;
            u_mem.dmem[12'h37F] = 8'h7F;
            u_mem.prog[0] = 16'h237F;
            go(8'h01, 5'h04, 4'h3, 2'h1, 21'h0);
            chk(ra, 32'h37F);
            chk(rs, 32'h1A);
            chk(rw, 32'h01);
            chk(wm, 32'h8);
            chk({24'h0, u_mem.dmem[12'h37F]}, 32'h80);
        end
    endtask

    task s_addc_zero;
        begin
            rst;
            u_mem.dmem[12'hFF0] = 8'hFF;
            u_mem.prog[0] = 16'h22F0;
            go(8'h00, 5'h11, 4'h5, 2'h3, 21'h0);
            chk(ra, 32'hFF0);
            chk(rs, 32'h07);
            chk({24'h0, u_mem.dmem[12'hFF0]}, 32'h00);
        end
    endtask

    task s_and_wreg_file_idx;
        begin
            rst;
            u_mem.dmem[12'h25F] = 8'h3C;
            u_mem.dmem[12'hF60] = 8'h8F;
            u_mem.prog[0] = 16'h165F;
            u_mem.prog[1] = 16'h1460;
            go(8'hF0, 5'h0B, 4'h0, 2'h3, 21'h0);
            chk(ra, 32'h25F);
            chk({24'h0, u_mem.dmem[12'h25F]}, 32'h30);
            chk(rw, 32'h80);
            chk(rs, 32'h1B);
            chk(rm, 32'h22);
            chk(wm, 32'h8);
        end
    endtask

    task s_and_literal_into_wreg;
        begin
            rst;
            u_mem.prog[0] = 16'h0B5F;
            u_mem.prog[1] = 16'h0B00;
            go(8'hA3, 5'h1F, 4'h0, 2'h1, 21'h0);
            chk(rw, 32'h00);
            chk(rs, 32'h0F);
            chk(rm | wm, 32'h0);
        end
    endtask

    // Starts the core and holds clk_en low at once; nothing may move until it returns.
    task s_freeze;
        begin
            rst;
            u_mem.prog[0] = 16'h0B0F;
            apb(1'b1, OFS_WREG, 32'hFF, rdv, er);
            apb(1'b1, OFS_CTRL, 32'h1, rdv, er);
            clk_en <= 1'b0;
            repeat (6) @(posedge pclk);
            #1;
            chk({11'h0, prog_addr}, 32'h0);
            chk({30'h0, q_phase}, {30'h0, Q1});
            @(posedge pclk);
            clk_en <= 1'b1;
            repeat (4) @(posedge pclk);
            apb(1'b0, OFS_WREG, 32'h0, rw, er);
            chk(rw, 32'h0F);
        end
    endtask

    task s_branch;
        int c;
        begin
            for (c = 0; c < 2; c++) begin
                rst;
                u_mem.prog[8'h10] = 16'hE2FE;
                u_mem.prog[8'h11] = 16'h0B0F;
                u_mem.prog[8'h0F] = 16'h0BF0;
                go(8'hFF, c ? 5'h0F : 5'h12, 4'h0, 2'h1, 21'h20);
                chk(rw, c ? 32'hF0 : 32'h0F);
                chk(pc12, c ? 32'h20 : 32'h26);
                chk(rs, c ? 32'h1B : 32'h02);
            end
        end
    endtask

    initial begin
        presetn = 1'b0;
        clk_en  = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        @(posedge pclk);
        s_regs;
        s_addc_w;
        s_addc_bank;
        s_addc_zero;
        s_and_wreg_file_idx;
        s_and_literal_into_wreg;
        s_freeze;
        s_branch;
        results;
    end
endmodule // add_and_carry_branch_exec_test
`default_nettype wire
